// ===== mrdbm_pkg.sv
package mrdbm_pkg;

    // ------------------------------------------------------------
    // Memory map
    // ------------------------------------------------------------
    localparam logic [15:0] IO_LO         = 16'h0000;
    localparam logic [15:0] IO_HI         = 16'h007F;
    localparam logic [15:0] XIO_LO        = 16'h0F80;
    localparam logic [15:0] XIO_HI        = 16'h0FFF;
    localparam logic [15:0] RAM_LO        = 16'h0090;
    localparam logic [15:0] GPR_LO        = 16'h0100;
    localparam logic [15:0] GPR_HI        = 16'h01FF;
    localparam logic [15:0] FLASH_LO      = 16'hC000;
    localparam logic [15:0] NVR_LO        = 16'hFFBB;
    localparam logic [15:0] NVR_HI        = 16'hFFBF;
    localparam logic [15:0] VEC_LO        = 16'hFFC0;
    localparam logic [15:0] RAM_TOP_FULL  = 16'h047F;
    localparam logic [15:0] RAM_TOP_MID   = 16'h028F;
    localparam logic [15:0] RAM_TOP_SMALL = 16'h018F;
    localparam logic [7:0]  DIR_IO_HI     = 8'h7F;
    localparam logic [7:0]  DIR_RAM_LO    = 8'h90;
    localparam logic [2:0]  BANK_RST      = 3'h0;

    // ------------------------------------------------------------
    // Region select bits
    // ------------------------------------------------------------
    localparam int REGION_W = 8;
    localparam int RG_IO    = 0;
    localparam int RG_XIO   = 1;
    localparam int RG_RAM   = 2;
    localparam int RG_GPR   = 3;
    localparam int RG_FLASH = 4;
    localparam int RG_NVR   = 5;
    localparam int RG_VEC   = 6;
    localparam int RG_NONE  = 7;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_BANK  = 4'h0;
    localparam logic [3:0] OFS_SYS   = 4'h4;
    localparam logic [3:0] OFS_LAST  = 4'h8;
    localparam logic [3:0] OFS_UNMAP = 4'hC;
    localparam int SYS_RSTOUT_BIT = 0;
    localparam int SYS_RSTIN_BIT  = 1;
    localparam int SYS_GPO_BIT    = 2;
    localparam int SYS_GPD_BIT    = 3;
    localparam int SYS_PIN_BIT    = 4;
    localparam int SYS_DBGLOW_BIT = 5;
    localparam int LAST_REG_LSB   = 16;
    localparam logic RSTOUT_RST = 1'b1;
    localparam logic RSTIN_RST = 1'b1;

endpackage

// ===== mrdbm_map_if.sv
`timescale 1ns/1ps
interface mrdbm_map_if;
    logic [15:0] req_addr;
    logic        direct;
    logic [2:0]  bank;
    logic [15:0] ram_top;
    logic [15:0] phys;
    logic        bank_ok;
    logic [7:0]  region;
    modport mapper  (input req_addr, direct, bank, ram_top, output phys, bank_ok);
    modport decoder (input phys, bank_ok, ram_top, output region);
    modport ctrl    (output req_addr, direct, bank, ram_top, input phys, bank_ok, region);
endinterface

// ===== mrdbm_bank_map.sv
`timescale 1ns/1ps
module mrdbm_bank_map (
    mrdbm_map_if.mapper m
);
    import mrdbm_pkg::*;

    logic [7:0] op;
    logic [3:0] bank_sel;

    always_comb begin
        op        = m.req_addr[7:0];
        bank_sel  = {1'b0, m.bank} + 4'h1;
        m.phys    = m.req_addr;
        m.bank_ok = 1'b1;
        if (m.direct) begin
            if (m.req_addr[15:8] != 8'h00) begin
                // Direct operands are one byte wide
                m.bank_ok = 1'b0;
            end else if (op <= DIR_IO_HI) begin
                m.phys = {8'h00, op};
            end else if (m.bank == BANK_RST) begin
                m.phys    = {8'h00, op};
                m.bank_ok = (op >= DIR_RAM_LO);
            end else begin
                m.phys    = {5'h00, bank_sel, op[6:0]};
                m.bank_ok = (m.phys <= m.ram_top);
            end
        end
    end

endmodule // mrdbm_bank_map

// ===== mrdbm_region_dec.sv
`timescale 1ns/1ps
module mrdbm_region_dec (
    mrdbm_map_if.decoder d
);
    import mrdbm_pkg::*;

    always_comb begin
        d.region = '0;
        // One bit per access, holes fall to unmapped
        if (!d.bank_ok) begin
            d.region[RG_NONE] = 1'b1;
        end else if (d.phys <= IO_HI) begin
            d.region[RG_IO] = 1'b1;
        end else if (d.phys >= XIO_LO && d.phys <= XIO_HI) begin
            d.region[RG_XIO] = 1'b1;
        end else if (d.phys >= GPR_LO && d.phys <= GPR_HI && d.phys <= d.ram_top) begin
            d.region[RG_GPR] = 1'b1;
        end else if (d.phys >= RAM_LO && d.phys <= d.ram_top) begin
            d.region[RG_RAM] = 1'b1;
        end else if (d.phys >= NVR_LO && d.phys <= NVR_HI) begin
            d.region[RG_NVR] = 1'b1;
        end else if (d.phys >= VEC_LO) begin
            d.region[RG_VEC] = 1'b1;
        end else if (d.phys >= FLASH_LO) begin
            d.region[RG_FLASH] = 1'b1;
        end else begin
            d.region[RG_NONE] = 1'b1;
        end
    end

endmodule // mrdbm_region_dec

// ===== mrdbm_top.sv
`timescale 1ns/1ps
module mrdbm_top #(
    parameter logic [15:0] RAM_TOP = mrdbm_pkg::RAM_TOP_FULL
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Avalon-MM register slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // CPU access decode
    input  wire logic        cpu_valid,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_direct,
    output logic             dec_valid,
    output logic [mrdbm_pkg::REGION_W-1:0] dec_region,
    output logic      [15:0] dec_phys,
    // Shared reset / port pin
    input  wire logic        rst_request,
    input  wire logic        shared_reset_port_pin_i,
    output logic             shared_reset_port_pin_o,
    output logic             shared_reset_port_pin_oe_n,
    output logic             ext_reset_n,
    output logic             gpio_in,
    // Debug pin
    input  wire logic        debug_mode,
    input  wire logic        debug_tx_low,
    input  wire logic        debug_comm_pin_i,
    output logic             debug_comm_pin_o,
    output logic             debug_comm_pin_oe_n,
    output logic             debug_rx
);
    import mrdbm_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wait_r;
        logic [31:0] rdata;
        logic [2:0]  bank;
        logic        rst_oe_en;
        logic        rst_in_sel;
        logic        gpo;
        logic        gpo_drv;
        logic        rst_s1;
        logic        rst_s2;
        logic        dbg_s1;
        logic        dbg_s2;
        logic        dbg_low_seen;
        logic        pin_o;
        logic        pin_oe_n;
        logic        ext_rst_n;
        logic        gpio_in;
        logic        dbg_oe_n;
        logic        dbg_rx;
        logic        dec_valid;
        logic [7:0]  dec_region;
        logic [15:0] dec_phys;
        logic [15:0] unmap_cnt;
    } mrdbm_state_type;

    // Pin drives reset low while the core is held in reset
    // Reset synchronisers start low to match, so no false release follows
    localparam mrdbm_state_type ST_RST = '{
        wait_r:     1'b1,
        rst_oe_en:  RSTOUT_RST,
        rst_in_sel: RSTIN_RST,
        dbg_s1:     1'b1,
        dbg_s2:     1'b1,
        pin_oe_n:   1'b0,
        ext_rst_n:  1'b0,
        gpio_in:    1'b1,
        dbg_oe_n:   1'b1,
        dbg_rx:     1'b1,
        default:    '0
    };

    mrdbm_state_type state_reg;
    mrdbm_state_type state_next;

    // ------------------------------------------------------------
    // Decode path
    // ------------------------------------------------------------
    mrdbm_map_if map_bus ();

    assign map_bus.req_addr = cpu_addr;
    assign map_bus.direct   = cpu_direct;
    assign map_bus.bank     = state_reg.bank;
    assign map_bus.ram_top  = RAM_TOP;

    mrdbm_bank_map u_bank_map (
        .m (map_bus)
    );

    mrdbm_region_dec u_region_dec (
        .d (map_bus)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic        bus_req;
    logic        bus_commit;
    logic [31:0] rd_mux;
    logic        unmap_hit;

    always_comb begin
        bus_req    = avs_read || avs_write;
        bus_commit = bus_req && !state_reg.wait_r;
        unmap_hit  = cpu_valid && map_bus.region[RG_NONE];
        rd_mux     = 32'h0000_0000;
        case (avs_address)
            OFS_BANK:  rd_mux[2:0] = state_reg.bank;
            OFS_SYS: begin
                rd_mux[SYS_RSTOUT_BIT] = state_reg.rst_oe_en;
                rd_mux[SYS_RSTIN_BIT]  = state_reg.rst_in_sel;
                rd_mux[SYS_GPO_BIT]    = state_reg.gpo;
                rd_mux[SYS_GPD_BIT]    = state_reg.gpo_drv;
                rd_mux[SYS_PIN_BIT]    = state_reg.rst_s2;
                rd_mux[SYS_DBGLOW_BIT] = state_reg.dbg_low_seen;
            end
            OFS_LAST:  rd_mux = {8'h00, state_reg.dec_region, state_reg.dec_phys};
            OFS_UNMAP: rd_mux[15:0] = state_reg.unmap_cnt;
            default:   rd_mux = 32'h0000_0000;
        endcase

        state_next = state_reg;

        // One wait cycle, then the answer stands for one cycle
        if (bus_req && state_reg.wait_r) begin
            state_next.wait_r = 1'b0;
            state_next.rdata  = avs_read ? rd_mux : 32'h0000_0000;
        end else begin
            state_next.wait_r = 1'b1;
        end

        if (bus_commit && avs_write && avs_byteenable[0]) begin
            case (avs_address)
                OFS_BANK: state_next.bank = avs_writedata[2:0];
                OFS_SYS: begin
                    state_next.rst_oe_en  = avs_writedata[SYS_RSTOUT_BIT];
                    state_next.rst_in_sel = avs_writedata[SYS_RSTIN_BIT];
                    state_next.gpo        = avs_writedata[SYS_GPO_BIT];
                    state_next.gpo_drv    = avs_writedata[SYS_GPD_BIT];
                    // Write one clears the sticky debug flag
                    if (avs_writedata[SYS_DBGLOW_BIT]) begin
                        state_next.dbg_low_seen = 1'b0;
                    end
                end
                default: state_next.bank = state_reg.bank;
            endcase
        end

        // A write to OFS_UNMAP clears the miss counter; a miss in that cycle still counts
        if (bus_commit && avs_write && avs_address == OFS_UNMAP) begin
            state_next.unmap_cnt = unmap_hit ? 16'h0001 : 16'h0000;
        end else if (unmap_hit && state_reg.unmap_cnt != 16'hFFFF) begin
            state_next.unmap_cnt = state_reg.unmap_cnt + 16'h0001;
        end

        // Registered decode result
        state_next.dec_valid = cpu_valid;
        if (cpu_valid) begin
            state_next.dec_region = map_bus.region;
            state_next.dec_phys   = map_bus.phys;
        end

        // Pin synchronisers
        state_next.rst_s1 = shared_reset_port_pin_i;
        state_next.rst_s2 = state_reg.rst_s1;
        state_next.dbg_s1 = debug_comm_pin_i;
        state_next.dbg_s2 = state_reg.dbg_s1;

        // Shared reset pin function select
        if (state_reg.rst_in_sel) begin
            state_next.pin_o     = 1'b0;
            state_next.pin_oe_n  = !(state_reg.rst_oe_en && rst_request);
            state_next.ext_rst_n = state_reg.rst_s2 && !rst_request;
            state_next.gpio_in   = 1'b1;
        end else begin
            state_next.pin_o     = state_reg.gpo;
            state_next.pin_oe_n  = !state_reg.gpo_drv;
            state_next.ext_rst_n = !rst_request;
            state_next.gpio_in   = state_reg.rst_s2;
        end

        // Open-drain single-wire debug link
        if (debug_mode) begin
            state_next.dbg_oe_n = !debug_tx_low;
            state_next.dbg_rx   = state_reg.dbg_s2;
        end else begin
            state_next.dbg_oe_n = 1'b1;
            state_next.dbg_rx   = 1'b1;
        end

        // Tool pulling the pin low during our reset output is flagged
        if (!state_reg.pin_oe_n && !state_reg.dbg_s2) begin
            state_next.dbg_low_seen = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_readdata               = state_reg.rdata;
    assign avs_waitrequest            = state_reg.wait_r;
    assign dec_valid                  = state_reg.dec_valid;
    assign dec_region                 = state_reg.dec_region;
    assign dec_phys                   = state_reg.dec_phys;
    assign shared_reset_port_pin_o    = state_reg.pin_o;
    assign shared_reset_port_pin_oe_n = state_reg.pin_oe_n;
    assign ext_reset_n                = state_reg.ext_rst_n;
    assign gpio_in                    = state_reg.gpio_in;
    assign debug_comm_pin_o           = 1'b0;
    assign debug_comm_pin_oe_n        = state_reg.dbg_oe_n;
    assign debug_rx                   = state_reg.dbg_rx;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [15:0] exp_bank_phys;
    logic        cpu_plain;
    logic        cpu_dir;

    assign exp_bank_phys = GPR_LO + {6'h00, state_reg.bank - 3'h1, 7'h00}
                         + {9'h000, cpu_addr[6:0]};
    assign cpu_plain     = cpu_valid && !cpu_direct;
    assign cpu_dir       = cpu_valid && cpu_direct && cpu_addr[15:8] == 8'h00;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_dec_latency: assert property (
        cpu_valid |=> dec_valid && dec_region != 8'h00
    ) else $error("decode result missing one cycle after request");

    a_one_region: assert property (
        dec_valid |-> $onehot(dec_region)
    ) else $error("decode did not give exactly one region");

    a_io_plain: assert property (
        cpu_plain && cpu_addr <= IO_HI |=> dec_region[RG_IO]
    ) else $error("plain access to io area not decoded as io");

    a_xio_plain: assert property (
        cpu_plain && cpu_addr >= XIO_LO && cpu_addr <= XIO_HI
        |=> dec_region[RG_XIO] && dec_phys == $past(cpu_addr)
    ) else $error("extended io access misdecoded");

    a_direct_io: assert property (
        cpu_dir && cpu_addr[7:0] <= DIR_IO_HI
        |=> dec_region[RG_IO] && dec_phys == $past(cpu_addr)
    ) else $error("direct io operand moved by bank pointer");

    a_bank_zero: assert property (
        cpu_dir && state_reg.bank == 3'h0 && cpu_addr[7:0] >= DIR_RAM_LO
        |=> dec_region[RG_RAM] && dec_phys == $past(cpu_addr)
    ) else $error("bank zero direct ram misdecoded");

    a_bank_map: assert property (
        cpu_dir && state_reg.bank != 3'h0 && cpu_addr[7]
        |=> dec_phys == $past(exp_bank_phys)
    ) else $error("banked direct address wrong");

    a_ram_limit: assert property (
        dec_valid && (dec_region[RG_RAM] || dec_region[RG_GPR])
        |-> dec_phys <= RAM_TOP && dec_phys >= RAM_LO
    ) else $error("ram select beyond implemented ram");

    a_gpr_plain: assert property (
        cpu_plain && cpu_addr >= GPR_LO && cpu_addr <= GPR_HI && cpu_addr <= RAM_TOP
        |=> dec_region[RG_GPR]
    ) else $error("register area not decoded");

    a_nvr_area: assert property (
        cpu_plain && cpu_addr >= NVR_LO && cpu_addr <= NVR_HI |=> dec_region[RG_NVR]
    ) else $error("non-volatile data area not decoded");

    a_vec_area: assert property (
        cpu_plain && cpu_addr >= VEC_LO |=> dec_region[RG_VEC]
    ) else $error("vector table not decoded");

    a_rst_drive: assert property (
        state_reg.rst_in_sel && state_reg.rst_oe_en && rst_request
        |=> !shared_reset_port_pin_oe_n && !shared_reset_port_pin_o
    ) else $error("reset output not driven");

    a_dbg_drive: assert property (
        debug_mode && debug_tx_low |=> !debug_comm_pin_oe_n ##0 !debug_comm_pin_o
    ) else $error("debug link not driven low");

    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest
    ) else $error("bus answer not one cycle after request");

    a_rst_release: assert property (
        state_reg.rst_in_sel && !rst_request |=> shared_reset_port_pin_oe_n
    ) else $error("reset output still driven without request");

    a_rst_out_off: assert property (
        state_reg.rst_in_sel && !state_reg.rst_oe_en |=> shared_reset_port_pin_oe_n
    ) else $error("reset output driven while disabled");

    a_port_mode: assert property (
        !state_reg.rst_in_sel
        |=> ext_reset_n == !$past(rst_request) && gpio_in == $past(state_reg.rst_s2)
    ) else $error("port mode pin function wrong");

    a_dbg_idle: assert property (
        !debug_mode |=> debug_comm_pin_oe_n && debug_rx
    ) else $error("debug pin active outside debug mode");

    a_dbg_rx: assert property (
        debug_mode |=> debug_rx == $past(state_reg.dbg_s2)
    ) else $error("debug receive level not passed on");

    a_dbg_flag: assert property (
        !state_reg.pin_oe_n && !state_reg.dbg_s2
        |=> state_reg.dbg_low_seen
    ) else $error("debug pin low during reset output not flagged");

    a_unmap_count: assert property (
        unmap_hit && !(bus_commit && avs_write) && state_reg.unmap_cnt != 16'hFFFF
        |=> state_reg.unmap_cnt == $past(state_reg.unmap_cnt) + 16'h0001
    ) else $error("unmapped access not counted");

    c_banked: cover property (cpu_dir && state_reg.bank == 3'h7 ##1 dec_region[RG_RAM]);
    c_unmapped: cover property (dec_valid && dec_region[RG_NONE]);
    c_gpio_mode: cover property (!state_reg.rst_in_sel && state_reg.gpo_drv);
    c_dbg_tx: cover property (debug_mode && !debug_comm_pin_oe_n);
    c_dbg_flag: cover property (state_reg.dbg_low_seen);

endmodule // mrdbm_top

// ===== mrdbm_cpu_model.sv
`timescale 1ns/1ps
module mrdbm_cpu_model (
    // Clock
    input  wire logic        clk,
    // Access request
    output logic             cpu_valid,
    output logic      [15:0] cpu_addr,
    output logic             cpu_direct
);
    initial begin
        cpu_valid  = 1'b0;
        cpu_addr   = 16'h0000;
        cpu_direct = 1'b0;
    end
    // ----------------------------------------
    // Requests
    // ----------------------------------------
    // No release here, so chained calls run back to back
    task automatic access(input logic [15:0] a, input logic dir);
        @(posedge clk);
        cpu_valid  <= 1'b1;
        cpu_addr   <= a;
        cpu_direct <= dir;
    endtask
    // Idle lines never show the last address
    task automatic idle();
        @(posedge clk);
        cpu_valid <= 1'b0;
        cpu_addr  <= ~cpu_addr;
    endtask
endmodule // mrdbm_cpu_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import mrdbm_pkg::*;
    typedef struct packed {
        logic [7:0]  region;
        logic [15:0] phys;
        logic        skip;
    } mrdbm_exp_type;
    logic              clk, arst_n, avs_read, avs_write, avs_waitrequest;
    logic       [3:0]  avs_address, avs_byteenable;
    logic       [31:0] avs_writedata, avs_readdata;
    logic              cpu_valid, cpu_direct, dec_valid;
    logic       [15:0] cpu_addr, dec_phys;
    logic       [7:0]  dec_region;
    logic              rst_request, rst_pin, rst_o, rst_oe_n, ext_reset_n, gpio_in;
    logic              debug_mode, debug_tx_low, dbg_pin, dbg_o, dbg_oe_n, debug_rx;
    logic              rst_pin_ext_n, dbg_tool_low;
    logic       [4:0]  pin_vec;
    localparam int PV_ROE = 0, PV_EXT = 1, PV_GPIO = 2, PV_DOE = 3, PV_RX = 4;
    mrdbm_exp_type     exp_q[$];
    mrdbm_exp_type     e_m, last;
    int                num_errors, n_checks, n_unmapped, cycles;
    // ----------------------------------------
    // Pins with pull-ups
    // ----------------------------------------
    assign rst_pin = (rst_oe_n === 1'b0 ? rst_o : 1'b1) & rst_pin_ext_n;
    assign dbg_pin = (dbg_oe_n === 1'b0 ? dbg_o : 1'b1) & ~dbg_tool_low;
    // Pin outputs read after the wait, not when the check is called
    assign pin_vec = {debug_rx, dbg_oe_n, gpio_in, ext_reset_n, rst_oe_n};
    mrdbm_top mrdbm_top_inst (
        .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr),
        .cpu_direct(cpu_direct), .dec_valid(dec_valid), .dec_region(dec_region),
        .dec_phys(dec_phys), .rst_request(rst_request), .shared_reset_port_pin_i(rst_pin),
        .shared_reset_port_pin_o(rst_o), .shared_reset_port_pin_oe_n(rst_oe_n),
        .ext_reset_n(ext_reset_n), .gpio_in(gpio_in), .debug_mode(debug_mode),
        .debug_tx_low(debug_tx_low), .debug_comm_pin_i(dbg_pin),
        .debug_comm_pin_o(dbg_o), .debug_comm_pin_oe_n(dbg_oe_n), .debug_rx(debug_rx));
    mrdbm_cpu_model mrdbm_cpu_model_inst (
        .clk(clk), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .cpu_direct(cpu_direct));
    always #50 clk = ~clk;
    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        avs_read      <= ~w;
        avs_write     <= w;
        avs_address   <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input string n, input logic [3:0] a, input logic [31:0] ex,
                       input logic [31:0] m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(n, q & m, ex);
    endtask
    task automatic go(input logic [2:0] bk, input logic [15:0] a, input logic dir,
                      input int rg, input logic [15:0] ph);
        mrdbm_exp_type e;
        if (dir) begin
            mrdbm_cpu_model_inst.idle();
            wr(OFS_BANK, {29'h0, bk});
        end
        e.region = 8'h01 << rg;
        e.phys   = ph;
        e.skip   = (rg == RG_NONE);
        if (rg == RG_NONE)
            n_unmapped++;
        exp_q.push_back(e);
        last = e;
        mrdbm_cpu_model_inst.access(a, dir);
    endtask
    task automatic pins(input string n, input int idx, input logic ex);
        repeat (6) @(posedge clk);
        chk(n, {31'h0, pin_vec[idx]}, {31'h0, ex});
    endtask
    // ----------------------------------------
    // Decode monitor and timeout
    // ----------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            complete_run();
        end
        if (arst_n === 1'b1 && dec_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk("dec_extra", 32'h1, 32'h0);
            else begin
                e_m = exp_q.pop_front();
                chk("dec_region", {24'h0, dec_region}, {24'h0, e_m.region});
                if (!e_m.skip)
                    chk("dec_phys", {16'h0, dec_phys}, {16'h0, e_m.phys});
            end
        end
    end
    initial begin
        {clk, arst_n, avs_read, avs_write, rst_request, debug_mode, debug_tx_low} = 7'h00;
        {avs_address, avs_writedata} = 36'h0;
        avs_byteenable = 4'hF;
        rst_pin_ext_n  = 1'b1;
        dbg_tool_low   = 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        pins("rst_oe_n", PV_ROE, 1'b1);
        chk("ext_reset_n", {31'h0, ext_reset_n}, 32'h1);
        rdc("bank", OFS_BANK, 32'h0, 32'h7);
        rdc("sys", OFS_SYS, 32'h13, 32'h3B);
        $display("test reset values done");
        wr(OFS_UNMAP, 32'h0);
        go(0, 16'h0000, 0, RG_IO, 16'h0000);
        go(0, 16'h007F, 0, RG_IO, 16'h007F);
        go(0, 16'h0080, 0, RG_NONE, 16'h0);
        go(0, 16'h0090, 0, RG_RAM, 16'h0090);
        go(0, 16'h0100, 0, RG_GPR, 16'h0100);
        go(0, 16'h01FF, 0, RG_GPR, 16'h01FF);
        go(0, 16'h0200, 0, RG_RAM, 16'h0200);
        go(0, 16'h047F, 0, RG_RAM, 16'h047F);
        go(0, 16'h0480, 0, RG_NONE, 16'h0);
        go(0, 16'h0F80, 0, RG_XIO, 16'h0F80);
        go(0, 16'h0FFF, 0, RG_XIO, 16'h0FFF);
        go(0, 16'hBFFF, 0, RG_NONE, 16'h0);
        go(0, 16'hC000, 0, RG_FLASH, 16'hC000);
        go(0, 16'hFFBA, 0, RG_FLASH, 16'hFFBA);
        go(0, 16'hFFBB, 0, RG_NVR, 16'hFFBB);
        go(0, 16'hFFBF, 0, RG_NVR, 16'hFFBF);
        go(0, 16'hFFC0, 0, RG_VEC, 16'hFFC0);
        go(0, 16'h007F, 1, RG_IO, 16'h007F);
        go(5, 16'h0010, 1, RG_IO, 16'h0010);
        go(0, 16'h0085, 1, RG_NONE, 16'h0);
        go(0, 16'h0090, 1, RG_RAM, 16'h0090);
        go(0, 16'h00FF, 1, RG_RAM, 16'h00FF);
        go(1, 16'h0080, 1, RG_GPR, 16'h0100);
        go(2, 16'h00FF, 1, RG_GPR, 16'h01FF);
        go(3, 16'h0080, 1, RG_RAM, 16'h0200);
        go(4, 16'h00FF, 1, RG_RAM, 16'h02FF);
        go(7, 16'h00FF, 1, RG_RAM, 16'h047F);
        go(6, 16'h0185, 1, RG_NONE, 16'h0);
        go(0, 16'hFFFF, 0, RG_VEC, 16'hFFFF);
        mrdbm_cpu_model_inst.idle();
        repeat (4) @(posedge clk);
        chk("pending", exp_q.size(), 32'h0);
        rdc("last", OFS_LAST, {8'h00, last.region, last.phys}, 32'hFFFFFFFF);
        rdc("unmapped", OFS_UNMAP, n_unmapped, 32'hFFFF);
        rdc("hole", 4'h2, 32'h0, 32'hFFFFFFFF);
        avs_byteenable <= 4'hE;
        wr(OFS_BANK, 32'h1);
        avs_byteenable <= 4'hF;
        rdc("bank_lane_off", OFS_BANK, 32'h6, 32'h7);
        $display("test decode done");
        // Tool breaks its own rule here so the sticky flag trips
        rst_request  <= 1'b1;
        dbg_tool_low <= 1'b1;
        pins("rst_drive", PV_ROE, 1'b0);
        chk("ext_reset_n", {31'h0, ext_reset_n}, 32'h0);
        rst_request  <= 1'b0;
        dbg_tool_low <= 1'b0;
        rdc("dbg_low_set", OFS_SYS, 32'h20, 32'h20);
        wr(OFS_SYS, 32'h23);
        rdc("dbg_low_clr", OFS_SYS, 32'h0, 32'h20);
        pins("rst_free", PV_EXT, 1'b1);
        rst_pin_ext_n <= 1'b0;
        pins("rst_in", PV_EXT, 1'b0);
        rst_pin_ext_n <= 1'b1;
        wr(OFS_SYS, 32'h2);
        rst_request <= 1'b1;
        pins("rst_out_off", PV_ROE, 1'b1);
        rst_request <= 1'b0;
        wr(OFS_SYS, 32'h0);
        rst_pin_ext_n <= 1'b0;
        pins("port_in", PV_GPIO, 1'b0);
        chk("port_no_rst", {31'h0, ext_reset_n}, 32'h1);
        rst_pin_ext_n <= 1'b1;
        wr(OFS_SYS, 32'h8);
        pins("port_drive_low", PV_GPIO, 1'b0);
        wr(OFS_SYS, 32'hC);
        pins("port_drive_high", PV_GPIO, 1'b1);
        wr(OFS_SYS, 32'h3);
        $display("test reset pin done");
        debug_mode   <= 1'b1;
        debug_tx_low <= 1'b1;
        pins("dbg_drive", PV_DOE, 1'b0);
        chk("dbg_rx", {31'h0, debug_rx}, 32'h0);
        debug_tx_low <= 1'b0;
        pins("dbg_rx_high", PV_RX, 1'b1);
        debug_mode <= 1'b0;
        $display("test debug pin done");
        complete_run();
    end
endmodule // tb
